/* File: logic/lut_access_regs.svh */
// Register map, field positions and table sizes of the table access block
// Assumes a word-wide register port addressed by byte offsets
// Notes on behaviour
// - Word 2 bit 31 bypasses port state
// - Word 2 bit 30 adds group id on multicast
// - Six-bit port mask, bit 0 is port 1
// - Word 3 group id and MAC high, word 4 low
// - 48 reserved addresses, indexed by low six bits
// - Writing one address updates its whole group
// - Reserved table shares control, data in word 2
// - Reserved read returns mask in word 2
// - Go flag self-clears when operation finishes
// - 4096 VLAN entries used while VLAN mode on
// - VLAN entry field set and widths
// - Forward choice selects membership or alternative
// - Group id hashed with destination address
// - Untag bit strips tag at egress port
// - Membership mask, bit 0 is port 1
// - VLAN write sequence, bit 7 self-clears
// - VLAN read loads three data words
// - Sixteen static entries, indirect access only
// - Table choice 0 selects static, 4-bit index
// - Word 1 flags, priority, spanning group
`ifndef LUT_ACCESS_REGS_SVH
`define LUT_ACCESS_REGS_SVH

// Register offsets
`define OFS_VLAN_W0 16'h0400
`define OFS_VLAN_W1 16'h0404
`define OFS_VLAN_W2 16'h0408
`define OFS_VLAN_IDX 16'h040c
`define OFS_VLAN_CTL 16'h0410
`define OFS_STA_CTL 16'h041c
`define OFS_STA_W1 16'h0420
`define OFS_STA_W2 16'h0424
`define OFS_STA_W3 16'h0428
`define OFS_STA_W4 16'h042c

// Writable bits per word, reset value
`define STA_W1_MASK 32'hfc000007
`define STA_W2_MASK 32'hc000003f
`define STA_W3_MASK 32'h007fffff
`define VLAN_W0_MASK 32'h8f00707f
`define VLAN_PORT_MASK 32'h0000007f
`define WORD_RST 32'h00000000

// Field positions
`define GO_BIT 7
`define ACT_BIT 0
`define SEL_BIT 1
`define CTL_IDX 13:8
`define VIDX 11:0
`define W1_VALID 31
`define W1_SRC 30
`define W1_DST 29
`define W1_PRIO 28:26
`define W1_SPAN 2:0
`define W2_BYPASS 31
`define W2_USEFID 30
`define W2_FWD 5:0
`define W3_FID 22:16
`define W3_MACHI 15:0
`define VW0_VALID 31
`define VW0_FOPT 27
`define VW0_PRIO 26:24
`define VW0_SPAN 14:12
`define VW0_FID 6:0
`define VW_PORTS 6:0
`define DA_MCAST 40

// Table sizes
`define STA_ENTRIES 16
`define RSVD_ADDRS 6'd48
`define RSVD_GROUPS 8
`define RSVD_PER_GRP 6'd6
`define VLAN_ENTRIES 4096
`define HASH_W 12
`define DA_W 48

`endif

/* File: logic/lut_access_pkg.sv */
// Entry types of the static and VLAN tables
// Assumes the constants header for all positions and sizes
package lut_access_pkg;

    // One static address entry, reserved bits dropped
    typedef struct packed {
        logic valid;
        logic src_drop;
        logic dst_drop;
        logic [2:0] prio;
        logic [2:0] span;
        logic bypass;
        logic multicast_group_match_enable;
        logic [5:0] fwd;
        logic [6:0] filter_group_id;
        logic [47:0] mac;
    } static_entry_t;

    // One VLAN entry
    typedef struct packed {
        logic valid;
        logic fwd_opt;
        logic [2:0] prio;
        logic [2:0] span;
        logic [6:0] filter_group_id;
        logic [6:0] untag;
        logic [6:0] member;
    } vlan_entry_t;

endpackage : lut_access_pkg

/* File: logic/static_match.sv */
// Parallel destination match over the static address entries
// Assumes entries and key come from the same clock domain
`timescale 1ns/10ps
`include "lut_access_regs.svh"
module static_match #(
    parameter int N = `STA_ENTRIES
) (
    input wire lut_access_pkg::static_entry_t tbl_in [N],
    input wire logic [47:0] da_in,
    input wire logic [6:0] fid_in,
    output logic hit_out,
    output logic [$clog2(N)-1:0] idx_out
);
    logic [N-1:0] match;

    for (genvar i = 0; i < N; i++) begin : g_ent
        assign match[i] = tbl_in[i].valid && tbl_in[i].mac == da_in &&
            (!(tbl_in[i].multicast_group_match_enable && da_in[`DA_MCAST]) ||
             tbl_in[i].filter_group_id == fid_in);
    end

    // Lowest matching entry wins
    always_comb begin
        hit_out = |match;
        idx_out = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (match[i]) begin
                idx_out = ($clog2(N))'(i);
            end
        end
    end
endmodule : static_match

/* File: logic/vlan_table.sv */
// VLAN entry storage with one write port and two read ports
// Assumes writes and reads on one clock; contents are not reset
`timescale 1ns/10ps
`include "lut_access_regs.svh"
module vlan_table #(
    parameter int DEPTH = `VLAN_ENTRIES
) (
    input wire logic core_clk_in,
    input wire logic wr_en_in,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
    input wire lut_access_pkg::vlan_entry_t wr_ent_in,
    input wire logic [$clog2(DEPTH)-1:0] cpu_idx_in,
    output lut_access_pkg::vlan_entry_t cpu_ent_out,
    input wire logic [$clog2(DEPTH)-1:0] lkp_idx_in,
    output lut_access_pkg::vlan_entry_t lkp_ent_out
);
    lut_access_pkg::vlan_entry_t mem [DEPTH];

    always_ff @(posedge core_clk_in) begin
        if (wr_en_in) begin
            mem[wr_idx_in] <= wr_ent_in;
        end
    end

    // Combinational reads
    assign cpu_ent_out = mem[cpu_idx_in];
    assign lkp_ent_out = mem[lkp_idx_in];
endmodule : vlan_table

/* File: logic/lut_access.sv */
// Indirect access to the static, reserved multicast and VLAN tables,
// with a one-stage lookup port for the forwarding engine
// Assumes register and lookup inputs come from the core clock domain
`timescale 1ns/10ps
`include "lut_access_regs.svh"
module lut_access #(
    parameter logic [47:0] RSVD_BASE = 48'h0180c2000000
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_ack_out,
    input wire logic vlan_mode_en_in,
    input wire logic lkp_req_in,
    input wire logic [11:0] lkp_vid_in,
    input wire logic [47:0] lkp_da_in,
    input wire logic [6:0] lkp_alt_mask_in,
    output logic lkp_valid_out,
    output logic vlan_hit_out,
    output logic [6:0] vlan_fwd_mask_out,
    output logic [6:0] vlan_untag_out,
    output logic [2:0] vlan_prio_out,
    output logic [2:0] vlan_span_out,
    output logic [11:0] hash_idx_out,
    output logic static_hit_out,
    output logic [5:0] static_fwd_mask_out,
    output logic static_bypass_out,
    output logic static_dst_drop_out,
    output logic rsvd_hit_out,
    output logic [5:0] rsvd_fwd_mask_out
);
    localparam int SIW = $clog2(`STA_ENTRIES);
    localparam int GW = $clog2(`RSVD_GROUPS);

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] w1_r, w2_r, w3_r, w4_r;
    logic [31:0] w1_nxt, w2_nxt, w3_nxt, w4_nxt;
    logic [31:0] vw0_r, vw1_r, vw2_r;
    logic [31:0] vw0_nxt, vw1_nxt, vw2_nxt;
    logic [5:0] sta_idx_r, sta_idx_nxt;
    logic sta_sel_r, sta_sel_nxt, sta_act_r, sta_act_nxt;
    logic sta_go_r, sta_go_nxt;
    logic [11:0] vlan_idx_r, vlan_idx_nxt;
    logic vlan_act_r, vlan_act_nxt, vlan_go_r, vlan_go_nxt;
    lut_access_pkg::static_entry_t sta_tbl_r [`STA_ENTRIES];
    lut_access_pkg::static_entry_t sta_tbl_nxt [`STA_ENTRIES];
    logic [5:0] grp_mask_r [`RSVD_GROUPS];
    logic [5:0] grp_mask_nxt [`RSVD_GROUPS];
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r;

    lut_access_pkg::static_entry_t w_ent, rd_ent;
    lut_access_pkg::vlan_entry_t vw_ent, vrd_ent, vlu_ent;
    logic [GW-1:0] cur_grp;
    logic [5:0] w2_fwd;
    logic [31:0] rd_mac_lo;
    logic sta_ctl_wr, vlan_ctl_wr;

    // Write strobe for one offset
    function automatic logic wr_at(input logic [15:0] ofs);
        return reg_wr_in && reg_addr_in == ofs;
    endfunction : wr_at

    ////////////////////////////////////////////////////////////////////
    // Data words packed into entries and back
    // word 1 flags and spanning group
    assign w_ent.valid = w1_r[`W1_VALID];
    assign w_ent.src_drop = w1_r[`W1_SRC];
    assign w_ent.dst_drop = w1_r[`W1_DST];
    assign w_ent.prio = w1_r[`W1_PRIO];
    assign w_ent.span = w1_r[`W1_SPAN];
    // bypass and match flags in word 2
    assign w_ent.bypass = w2_r[`W2_BYPASS];
    assign w_ent.multicast_group_match_enable = w2_r[`W2_USEFID];
    assign w_ent.fwd = w2_r[`W2_FWD];
    // group id and MAC split over words
    assign w_ent.filter_group_id = w3_r[`W3_FID];
    assign w_ent.mac = {w3_r[`W3_MACHI], w4_r};
    assign vw_ent.valid = vw0_r[`VW0_VALID];
    assign vw_ent.fwd_opt = vw0_r[`VW0_FOPT];
    assign vw_ent.prio = vw0_r[`VW0_PRIO];
    assign vw_ent.span = vw0_r[`VW0_SPAN];
    assign vw_ent.filter_group_id = vw0_r[`VW0_FID];
    assign vw_ent.untag = vw1_r[`VW_PORTS];
    assign vw_ent.member = vw2_r[`VW_PORTS];

    assign rd_ent = sta_tbl_r[sta_idx_r[SIW-1:0]];
    assign rd_mac_lo = rd_ent.mac[31:0];
    assign w2_fwd = w2_r[`W2_FWD];
    assign cur_grp = GW'(sta_idx_r / `RSVD_PER_GRP);
    // Written out so the strobe is in the sensitivity of the assignment
    assign sta_ctl_wr = reg_wr_in && reg_addr_in == `OFS_STA_CTL;
    assign vlan_ctl_wr = reg_wr_in && reg_addr_in == `OFS_VLAN_CTL;

    vlan_table #(
        .DEPTH(`VLAN_ENTRIES)
    ) u_vlan (
        .core_clk_in(core_clk_in),
        .wr_en_in(vlan_go_r && !vlan_act_r),
        .wr_idx_in(vlan_idx_r),
        .wr_ent_in(vw_ent),
        .cpu_idx_in(vlan_idx_r),
        .cpu_ent_out(vrd_ent),
        .lkp_idx_in(lkp_vid_in),
        .lkp_ent_out(vlu_ent)
    );

    ////////////////////////////////////////////////////////////////////
    // Register writes and table operations
    always_comb begin
        w1_nxt = w1_r;
        w2_nxt = w2_r;
        w3_nxt = w3_r;
        w4_nxt = w4_r;
        vw0_nxt = vw0_r;
        vw1_nxt = vw1_r;
        vw2_nxt = vw2_r;
        sta_idx_nxt = sta_idx_r;
        sta_sel_nxt = sta_sel_r;
        sta_act_nxt = sta_act_r;
        sta_go_nxt = sta_go_r;
        vlan_idx_nxt = vlan_idx_r;
        vlan_act_nxt = vlan_act_r;
        vlan_go_nxt = vlan_go_r;
        sta_tbl_nxt = sta_tbl_r;
        grp_mask_nxt = grp_mask_r;
        // Software writes, reserved bits kept at zero
        if (wr_at(`OFS_STA_W1)) w1_nxt = reg_wdata_in & `STA_W1_MASK;
        if (wr_at(`OFS_STA_W2)) w2_nxt = reg_wdata_in & `STA_W2_MASK;
        if (wr_at(`OFS_STA_W3)) w3_nxt = reg_wdata_in & `STA_W3_MASK;
        if (wr_at(`OFS_STA_W4)) w4_nxt = reg_wdata_in;
        if (wr_at(`OFS_VLAN_W0)) vw0_nxt = reg_wdata_in & `VLAN_W0_MASK;
        if (wr_at(`OFS_VLAN_W1)) vw1_nxt = reg_wdata_in & `VLAN_PORT_MASK;
        if (wr_at(`OFS_VLAN_W2)) vw2_nxt = reg_wdata_in & `VLAN_PORT_MASK;
        if (wr_at(`OFS_VLAN_IDX)) vlan_idx_nxt = reg_wdata_in[`VIDX];
        if (sta_ctl_wr && !sta_go_r) begin
            sta_idx_nxt = reg_wdata_in[`CTL_IDX];
            sta_sel_nxt = reg_wdata_in[`SEL_BIT];
            sta_act_nxt = reg_wdata_in[`ACT_BIT];
            sta_go_nxt = reg_wdata_in[`GO_BIT];
        end
        if (vlan_ctl_wr && !vlan_go_r) begin
            vlan_act_nxt = reg_wdata_in[`ACT_BIT];
            vlan_go_nxt = reg_wdata_in[`GO_BIT];
        end
        if (sta_go_r) begin
            sta_go_nxt = 1'b0;
            if (!sta_sel_r) begin
                if (sta_act_r) begin
                    w1_nxt = `WORD_RST;
                    w1_nxt[`W1_VALID] = rd_ent.valid;
                    w1_nxt[`W1_SRC] = rd_ent.src_drop;
                    w1_nxt[`W1_DST] = rd_ent.dst_drop;
                    w1_nxt[`W1_PRIO] = rd_ent.prio;
                    w1_nxt[`W1_SPAN] = rd_ent.span;
                    w2_nxt = `WORD_RST;
                    w2_nxt[`W2_BYPASS] = rd_ent.bypass;
                    w2_nxt[`W2_USEFID] = rd_ent.multicast_group_match_enable;
                    w2_nxt[`W2_FWD] = rd_ent.fwd;
                    w3_nxt = `WORD_RST;
                    w3_nxt[`W3_FID] = rd_ent.filter_group_id;
                    w3_nxt[`W3_MACHI] = rd_ent.mac[47:32];
                    w4_nxt = rd_mac_lo;
                end else begin
                    sta_tbl_nxt[sta_idx_r[SIW-1:0]] = w_ent;
                end
            end else if (sta_idx_r < `RSVD_ADDRS) begin
                // reserved table uses word 2 only
                if (sta_act_r) begin
                    w2_nxt[`W2_FWD] = grp_mask_r[cur_grp];
                end else begin
                    grp_mask_nxt[cur_grp] = w2_fwd;
                end
            end else if (sta_act_r) begin
                w2_nxt[`W2_FWD] = '0;
            end
        end
        if (vlan_go_r) begin
            vlan_go_nxt = 1'b0;
            if (vlan_act_r) begin
                vw0_nxt = `WORD_RST;
                vw0_nxt[`VW0_VALID] = vrd_ent.valid;
                vw0_nxt[`VW0_FOPT] = vrd_ent.fwd_opt;
                vw0_nxt[`VW0_PRIO] = vrd_ent.prio;
                vw0_nxt[`VW0_SPAN] = vrd_ent.span;
                vw0_nxt[`VW0_FID] = vrd_ent.filter_group_id;
                vw1_nxt = `WORD_RST;
                vw1_nxt[`VW_PORTS] = vrd_ent.untag;
                vw2_nxt = `WORD_RST;
                vw2_nxt[`VW_PORTS] = vrd_ent.member;
            end
        end
    end

    // Register read mux, unmapped offsets read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `OFS_STA_W1: rdata_nxt = w1_r;
                `OFS_STA_W2: rdata_nxt = w2_r;
                `OFS_STA_W3: rdata_nxt = w3_r;
                `OFS_STA_W4: rdata_nxt = w4_r;
                `OFS_VLAN_W0: rdata_nxt = vw0_r;
                `OFS_VLAN_W1: rdata_nxt = vw1_r;
                `OFS_VLAN_W2: rdata_nxt = vw2_r;
                `OFS_VLAN_IDX: rdata_nxt = 32'(vlan_idx_r);
                `OFS_STA_CTL: begin
                    rdata_nxt = `WORD_RST;
                    rdata_nxt[`CTL_IDX] = sta_idx_r;
                    rdata_nxt[`GO_BIT] = sta_go_r;
                    rdata_nxt[`SEL_BIT] = sta_sel_r;
                    rdata_nxt[`ACT_BIT] = sta_act_r;
                end
                `OFS_VLAN_CTL: begin
                    rdata_nxt = `WORD_RST;
                    rdata_nxt[`GO_BIT] = vlan_go_r;
                    rdata_nxt[`ACT_BIT] = vlan_act_r;
                end
                default: rdata_nxt = `WORD_RST;
            endcase
        end
    end

    // Register state flops
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            w1_r <= `WORD_RST;
            w2_r <= `WORD_RST;
            w3_r <= `WORD_RST;
            w4_r <= `WORD_RST;
            vw0_r <= `WORD_RST;
            vw1_r <= `WORD_RST;
            vw2_r <= `WORD_RST;
            sta_idx_r <= '0;
            sta_sel_r <= 1'b0;
            sta_act_r <= 1'b0;
            sta_go_r <= 1'b0;
            vlan_idx_r <= '0;
            vlan_act_r <= 1'b0;
            vlan_go_r <= 1'b0;
            sta_tbl_r <= '{default: '0};
            grp_mask_r <= '{default: '0};
            rdata_r <= `WORD_RST;
            ack_r <= 1'b0;
        end else begin
            w1_r <= w1_nxt;
            w2_r <= w2_nxt;
            w3_r <= w3_nxt;
            w4_r <= w4_nxt;
            vw0_r <= vw0_nxt;
            vw1_r <= vw1_nxt;
            vw2_r <= vw2_nxt;
            sta_idx_r <= sta_idx_nxt;
            sta_sel_r <= sta_sel_nxt;
            sta_act_r <= sta_act_nxt;
            sta_go_r <= sta_go_nxt;
            vlan_idx_r <= vlan_idx_nxt;
            vlan_act_r <= vlan_act_nxt;
            vlan_go_r <= vlan_go_nxt;
            sta_tbl_r <= sta_tbl_nxt;
            grp_mask_r <= grp_mask_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= reg_rd_in;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign reg_ack_out = ack_r;

    ////////////////////////////////////////////////////////////////////
    // Lookup stage
    logic use_vlan, sta_hit, rsvd_hit;
    logic [SIW-1:0] sta_hit_idx;
    logic [6:0] fid_l;
    logic [5:0] rsvd_idx;
    logic [`HASH_W-1:0] hash_c;
    logic [6:0] lk_fwd_nxt, lk_untag_nxt;
    logic [48:0] lk_r, lk_nxt;
    logic lk_valid_r;

    // VLAN entry used only in VLAN mode
    assign use_vlan = vlan_mode_en_in && vlu_ent.valid;
    assign fid_l = use_vlan ? vlu_ent.filter_group_id : '0;
    // indexed by low six address bits
    assign rsvd_idx = lkp_da_in[5:0];
    assign rsvd_hit = lkp_da_in[47:6] == RSVD_BASE[47:6] &&
        rsvd_idx < `RSVD_ADDRS;

    static_match #(
        .N(`STA_ENTRIES)
    ) u_match (
        .tbl_in(sta_tbl_r),
        .da_in(lkp_da_in),
        .fid_in(fid_l),
        .hit_out(sta_hit),
        .idx_out(sta_hit_idx)
    );

    // Next lookup results
    always_comb begin
        lk_fwd_nxt = lkp_alt_mask_in;
        lk_untag_nxt = '0;
        // membership bit 0 is port 1
        if (use_vlan && vlu_ent.fwd_opt) lk_fwd_nxt = vlu_ent.member;
        if (use_vlan) lk_untag_nxt = vlu_ent.untag;
        hash_c = `HASH_W'(fid_l);
        for (int k = 0; k < `DA_W / `HASH_W; k++) begin
            hash_c = hash_c ^ lkp_da_in[k*`HASH_W +: `HASH_W];
        end
        lk_nxt = lk_r;
        if (lkp_req_in) begin
            lk_nxt = {use_vlan, lk_fwd_nxt, lk_untag_nxt,
                use_vlan ? vlu_ent.prio : 3'h0,
                use_vlan ? vlu_ent.span : 3'h0, hash_c, sta_hit,
                sta_hit ? sta_tbl_r[sta_hit_idx].fwd : 6'h0,
                sta_hit && sta_tbl_r[sta_hit_idx].bypass,
                sta_hit && sta_tbl_r[sta_hit_idx].dst_drop, rsvd_hit,
                rsvd_hit ? grp_mask_r[GW'(rsvd_idx / `RSVD_PER_GRP)]
                    : 6'h0};
        end
    end

    // Lookup flops
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lk_r <= '0;
            lk_valid_r <= 1'b0;
        end else begin
            lk_r <= lk_nxt;
            lk_valid_r <= lkp_req_in;
        end
    end

    assign lkp_valid_out = lk_valid_r;
    assign {vlan_hit_out, vlan_fwd_mask_out, vlan_untag_out, vlan_prio_out,
        vlan_span_out, hash_idx_out, static_hit_out, static_fwd_mask_out,
        static_bypass_out, static_dst_drop_out, rsvd_hit_out,
        rsvd_fwd_mask_out} = lk_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_sta_go_clear: assert property (sta_go_r |=> !sta_go_r)
        else $error("static go flag did not clear");
    a_vlan_go_cycle: assert property (
        (vlan_ctl_wr && !vlan_go_r && reg_wdata_in[`GO_BIT])
        |=> vlan_go_r ##1 !vlan_go_r)
        else $error("VLAN go flag not one cycle");
    a_ctl_ignore: assert property (
        (sta_go_r && sta_ctl_wr) |=> $stable(sta_idx_r) && !sta_go_r)
        else $error("command taken while pending");
    a_rsvd_group: assert property (
        (sta_go_r && sta_sel_r && !sta_act_r && sta_idx_r < `RSVD_ADDRS)
        |=> grp_mask_r[$past(cur_grp)] == $past(w2_fwd))
        else $error("group mask not written");
    a_static_read: assert property (
        (sta_go_r && !sta_sel_r && sta_act_r) |=> w4_r == $past(rd_mac_lo))
        else $error("static read data wrong");
    a_vlan_mode_off: assert property (
        (lkp_req_in && !vlan_mode_en_in) |=> !vlan_hit_out &&
        vlan_untag_out == '0 && vlan_fwd_mask_out == $past(lkp_alt_mask_in))
        else $error("VLAN entry used with mode off");
    a_w3_reserved: assert property (
        (reg_rd_in && reg_addr_in == `OFS_STA_W3)
        |=> reg_ack_out && reg_rdata_out[31:23] == '0)
        else $error("word 3 reserved bits not zero");
    a_static_mask: assert property (
        (lkp_valid_out && !static_hit_out)
        |-> static_fwd_mask_out == '0 && !static_bypass_out)
        else $error("mask without static hit");
endmodule : lut_access

/* File: tb/lut_access_tb_top.sv */
// Bench for the table access block: random and corner table traffic
// Assumes the constants header and one core clock for all ports
`timescale 1ns/10ps
`include "lut_access_regs.svh"
module lut_access_tb_top;
localparam logic [47:0] RB = 48'h0180c2000000;
localparam logic [31:0] SM [4] = '{`STA_W1_MASK, `STA_W2_MASK,
    `STA_W3_MASK, 32'hffffffff};
logic core_clk_in, rst_b_in, reg_wr_in, reg_rd_in, reg_ack_out;
logic vlan_mode_en_in, lkp_req_in, lkp_valid_out, vlan_hit_out;
logic static_hit_out, static_bypass_out, static_dst_drop_out;
logic rsvd_hit_out, h;
logic [2:0] vlan_prio_out, vlan_span_out;
logic [5:0] static_fwd_mask_out, rsvd_fwd_mask_out, ix, ox;
logic [6:0] lkp_alt_mask_in, vlan_fwd_mask_out, vlan_untag_out, alt;
logic [11:0] lkp_vid_in, hash_idx_out, vid, hx;
logic [15:0] reg_addr_in;
logic [31:0] reg_wdata_in, reg_rdata_out, d;
logic [47:0] lkp_da_in, da;
logic [31:0] w [4];
logic [5:0] rg [8] = '{default: 6'h00};
int failures = 0;
int tests_run = 0;
////////////////////////////////////////
lut_access #(.RSVD_BASE(RB)) lut_access_inst (.core_clk_in, .rst_b_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
    .reg_ack_out, .vlan_mode_en_in, .lkp_req_in, .lkp_vid_in, .lkp_da_in,
    .lkp_alt_mask_in, .lkp_valid_out, .vlan_hit_out, .vlan_fwd_mask_out,
    .vlan_untag_out, .vlan_prio_out, .vlan_span_out, .hash_idx_out,
    .static_hit_out, .static_fwd_mask_out, .static_bypass_out,
    .static_dst_drop_out, .rsvd_hit_out, .rsvd_fwd_mask_out);
// Core clock, 8 ns
initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
end
// Counts a comparison, reports a mismatch
task chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
        failures++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : chk
// Register write, one-cycle strobe
task wr(input logic [15:0] a, input logic [31:0] v);
    @(negedge core_clk_in);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
endtask : wr
// Register read, answer one cycle later
task rd(input logic [15:0] a);
    @(negedge core_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    chk(reg_ack_out, 1'b1);
    d = reg_rdata_out;
endtask : rd
// Table command; go flag must then read clear
task cmd(input logic [15:0] a, input logic [31:0] v);
    wr(a, v);
    rd(a);
    chk(d[`GO_BIT], 1'b0);
endtask : cmd
// Lookup request, results one cycle later
task lk(input logic [11:0] id, input logic [47:0] a, input logic [6:0] m);
    @(negedge core_clk_in);
    lkp_vid_in = id;
    lkp_da_in = a;
    lkp_alt_mask_in = m;
    lkp_req_in = 1'b1;
    @(negedge core_clk_in);
    lkp_req_in = 1'b0;
    chk(lkp_valid_out, 1'b1);
endtask : lk
// Counts and verdict, ends the run
task test_done;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask : test_done
// Watchdog well beyond the expected run
initial begin
    #100000;
    failures++;
    test_done;
end
////////////////////////////////////////
// Main sequence
initial begin
    {rst_b_in, reg_wr_in, reg_rd_in, vlan_mode_en_in, lkp_req_in} = '0;
    {reg_addr_in, reg_wdata_in, lkp_vid_in, lkp_da_in, lkp_alt_mask_in} = '0;
    void'($urandom(28503));
    repeat (12) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_b_in = 1'b1;
    rd(16'h0500);
    chk(d, 32'h0);
    // Static entries: store, wipe words, read back, look up
    for (int i = 0; i < 2; i++) begin
        w = '{$urandom | 32'h80000000, $urandom, $urandom, $urandom};
        w[2][8] = i[0];
        w[1][30] = i[0];
        ix = i ? 6'h0f : 6'($urandom_range(14));
        for (int k = 0; k < 4; k++)
            wr(`OFS_STA_W1 + 16'(4 * k), w[k]);
        cmd(`OFS_STA_CTL, {18'h0, ix, 8'h80});
        for (int k = 0; k < 4; k++)
            wr(`OFS_STA_W1 + 16'(4 * k), 32'h0);
        cmd(`OFS_STA_CTL, {18'h0, ix, 8'h81});
        for (int k = 0; k < 4; k++) begin
            rd(`OFS_STA_W1 + 16'(4 * k));
            chk(d, w[k] & SM[k]);
        end
        // Multicast entry with group match hits only on group id 0
        h = !i[0] || w[2][22:16] == 7'h0;
        lk(12'h0, {w[2][15:0], w[3]}, 7'h0);
        chk({static_hit_out, static_bypass_out}, {h, h & w[1][31]});
        chk(static_hit_out, h);
        chk(static_dst_drop_out, h & w[0][29]);
        chk(static_fwd_mask_out, h ? w[1][5:0] : 6'h0);
    end
    // Second command while the first is pending is ignored
    @(negedge core_clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} = {`OFS_STA_CTL, 32'h0f80, 1'b1};
    @(negedge core_clk_in);
    reg_wdata_in = 32'h0381;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    rd(`OFS_STA_CTL);
    chk(d, 32'h0f00);
    // Reserved table: write one address, read a group mate, look up
    for (int i = 0; i < 4; i++) begin
        ix = 6'($urandom_range(47));
        ox = 6'(ix / 6 * 6 + $urandom_range(5));
        w[0] = $urandom;
        rg[ix / 6] = w[0][5:0];
        wr(`OFS_STA_W2, w[0]);
        cmd(`OFS_STA_CTL, {18'h0, ix, 8'h82});
        cmd(`OFS_STA_CTL, {18'h0, ox, 8'h83});
        rd(`OFS_STA_W2);
        chk(d[5:0], rg[ox / 6]);
        lk(12'h0, RB | 48'(ox), 7'h0);
        chk({rsvd_hit_out, rsvd_fwd_mask_out}, {1'b1, rg[ox / 6]});
    end
    lk(12'h0, RB | 48'h30, 7'h0);
    chk(rsvd_hit_out, 1'b0);
    // VLAN entries: store, wipe, read back, look up with mode on and off
    for (int i = 0; i < 2; i++) begin
        w = '{$urandom | 32'h80000000, $urandom, $urandom, 32'h0};
        w[0][27] = i[0];
        vid = i ? 12'($urandom) : 12'hfff;
        for (int k = 0; k < 3; k++)
            wr(`OFS_VLAN_W0 + 16'(4 * k), w[k]);
        wr(`OFS_VLAN_IDX, {20'h0, vid});
        cmd(`OFS_VLAN_CTL, 32'h80);
        for (int k = 0; k < 3; k++)
            wr(`OFS_VLAN_W0 + 16'(4 * k), 32'h0);
        cmd(`OFS_VLAN_CTL, 32'h81);
        for (int k = 0; k < 3; k++) begin
            rd(`OFS_VLAN_W0 + 16'(4 * k));
            chk(d, w[k] & (k ? `VLAN_PORT_MASK : `VLAN_W0_MASK));
        end
        vlan_mode_en_in = 1'b1;
        da = {16'($urandom), $urandom};
        alt = 7'($urandom);
        hx = {5'h0, w[0][6:0]} ^ da[47:36] ^ da[35:24] ^ da[23:12] ^ da[11:0];
        lk(vid, da, alt);
        chk({vlan_hit_out, vlan_untag_out}, {1'b1, w[1][6:0]});
        chk(vlan_fwd_mask_out, i ? w[2][6:0] : alt);
        chk({vlan_prio_out, vlan_span_out}, {w[0][26:24], w[0][14:12]});
        chk(hash_idx_out, hx);
        vlan_mode_en_in = 1'b0;
        lk(vid, da, alt);
        chk({vlan_hit_out, vlan_untag_out, vlan_fwd_mask_out}, {8'h0, alt});
    end
    test_done;
end
endmodule : lut_access_tb_top
